// >>> clk_ratio_decode.sv
// turns divisor codes into divide factors for the clock tree
`timescale 1ns/10ps
`default_nettype none
`include "osc_clk_params.svh"
module clk_ratio_decode (
  input wire logic [4:0] pre_code,
  input wire logic [1:0] post_code,
  input wire logic [8:0] fbd_code,
  input wire logic [2:0] fast_rc_code,
  input wire logic [2:0] doze_code,
  input wire logic doze_enable,
  output osc_clk_pkg::clk_div_t ratio
);
  wire [3:0] post_div = (post_code == `POST_CODE_DIV2) ? `POST_DIV2 :
                        (post_code == `POST_CODE_DIV4) ? `POST_DIV4 :
                        (post_code == `POST_CODE_DIV8) ? `POST_DIV8 : `POST_DIV_RESERVED;
  wire [8:0] fast_rc_div = (fast_rc_code == `FAST_RC_TOP_CODE) ? `FAST_RC_TOP_DIV :
                           9'(`FAST_RC_UNIT_DIV << fast_rc_code);
  wire [7:0] doze_div = doze_enable ? 8'(`DOZE_UNIT_DIV << doze_code) : `DOZE_UNIT_DIV;
  assign ratio.pre_div = {1'b0, pre_code} + `PRE_DIV_OFFSET;
  assign ratio.post_div = post_div;
  assign ratio.fb_mult = {1'b0, fbd_code} + `FBD_MULT_OFFSET;
  assign ratio.fast_rc_div = fast_rc_div;
  assign ratio.doze_div = doze_div;
  assign ratio.fcy_div = `FCY_DIV;
endmodule
`default_nettype wire

// >>> osc_clk_ctrl.sv
// oscillator source selection, clock switching and clock divisor registers on APB
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "osc_clk_params.svh"
module osc_clk_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic warm_rst,
  input wire logic [2:0] start_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic [1:0] switch_monitor_cfg,
  input wire logic pll_lock_raw,
  input wire logic osc_ready_raw,
  input wire logic new_clk_raw,
  input wire logic clk_fail_raw,
  input wire logic irq_event,
  input wire logic pps_wr_req,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] current_source,
  output logic [2:0] target_source,
  output logic [1:0] primary_submode,
  output logic pll_enable,
  output logic secondary_osc_enable,
  output logic pps_wr_grant,
  output logic switch_busy,
  output osc_clk_pkg::clk_div_t clk_div
);
  osc_clk_pkg::osc_cfg_t cfg_reg;
  osc_clk_pkg::sw_state_t state_reg;
  osc_clk_pkg::sw_state_t state_next;
  osc_clk_pkg::clk_div_t ratio;
  logic [2:0] next_reg;
  logic clock_lock_reg;
  logic pin_lock_reg;
  logic pll_lock_reg;
  logic fail_reg;
  logic sw_req_reg;
  logic recover_reg;
  logic [2:0] doze_reg;
  logic doze_enable_reg;
  logic [2:0] fast_rc_reg;
  logic [1:0] post_reg;
  logic [4:0] pre_reg;
  logic [8:0] fbd_reg;
  logic [1:0] unlock_reg;
  logic [3:0] settle_cnt_reg;
  logic [3:0] sync_out;
  logic new_clk_prev_reg;
  logic fail_prev_reg;

  // synchronised oscillator-side levels
  osc_sync3 #(.WIDTH(4)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({clk_fail_raw, new_clk_raw, osc_ready_raw, pll_lock_raw}),
    .stable_out(sync_out)
  );
  wire pll_lock_s = sync_out[0];
  wire osc_ready_s = sync_out[1];
  wire new_clk_s = sync_out[2];
  wire fail_s = sync_out[3];
  wire new_clk_rise = new_clk_s & ~new_clk_prev_reg;
  wire fail_rise = fail_s & ~fail_prev_reg;

  // configuration decode
  wire sw_enabled = ~cfg_reg.switch_monitor[`OSC_SWMON_DISABLE_BIT];
  wire lock_active = (cfg_reg.switch_monitor == `OSC_SWMON_SWITCH_ONLY) & clock_lock_reg;
  wire monitor_on = cfg_reg.switch_monitor == `OSC_SWMON_BOTH;

  // APB decode
  wire setup = psel & ~penable;
  wire wr_done = psel & penable & pready & pwrite;
  wire sel_ctrl = paddr == `OSC_ADDR_CTRL;
  wire sel_div = paddr == `OSC_ADDR_DIV;
  wire sel_fbd = paddr == `OSC_ADDR_FBD;
  wire sel_key = paddr == `OSC_ADDR_KEY;
  wire addr_hit = sel_ctrl | sel_div | sel_fbd | sel_key;
  wire [15:0] wdata = pwdata[15:0];
  wire unlocked = unlock_reg == 2'h2;
  wire ctrl_wr = wr_done & sel_ctrl & unlocked;
  wire div_wr = wr_done & sel_div;
  wire fbd_wr = wr_done & sel_fbd;
  wire key_wr = wr_done & sel_key;

  // read words; unimplemented positions are constant zero
  wire [15:0] ctrl_rd = {1'b0, current_source, 1'b0, next_reg, clock_lock_reg, pin_lock_reg,
                         pll_lock_reg, 1'b0, fail_reg, 1'b0, secondary_osc_enable, sw_req_reg};
  wire [15:0] div_rd = {recover_reg, doze_reg, doze_enable_reg, fast_rc_reg, post_reg, 1'b0, pre_reg};
  wire [15:0] fbd_rd = {7'h00, fbd_reg};
  wire [15:0] rd_word = sel_ctrl ? ctrl_rd :
                        sel_div ? div_rd :
                        sel_fbd ? fbd_rd : 16'h0000;

  // switch sequencing terms
  wire req_pending = (state_reg == osc_clk_pkg::ST_IDLE) & sw_req_reg & sw_enabled;
  wire abort_req = req_pending & (next_reg == current_source);
  wire valid_start = req_pending & (next_reg != current_source);
  wire tgt_pll = (target_source == `OSC_SRC_FAST_RC_PLL) | (target_source == `OSC_SRC_PRIMARY_PLL);
  wire cur_pll = (current_source == `OSC_SRC_FAST_RC_PLL) | (current_source == `OSC_SRC_PRIMARY_PLL);
  wire new_ready = osc_ready_s & (~tgt_pll | pll_lock_s);
  wire settle_done = (state_reg == osc_clk_pkg::ST_SETTLE) & new_clk_rise &
                     (settle_cnt_reg == `SETTLE_EDGES - 4'h1);
  wire req_set = ctrl_wr & wdata[`CTRL_SWITCH_REQ_BIT] & sw_enabled & ~lock_active;
  wire pll_in_use = cur_pll | ((state_reg != osc_clk_pkg::ST_IDLE) & tgt_pll);
  wire fail_clear = (ctrl_wr & ~wdata[`CTRL_FAIL_BIT]) | valid_start;
  wire fail_set = monitor_on & fail_rise;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      osc_clk_pkg::ST_IDLE: begin
        if (valid_start) begin
          state_next = osc_clk_pkg::ST_WAIT_READY;
        end
      end
      osc_clk_pkg::ST_WAIT_READY: begin
        if (new_ready) begin
          state_next = osc_clk_pkg::ST_SETTLE;
        end
      end
      osc_clk_pkg::ST_SETTLE: begin
        if (settle_done) begin
          state_next = osc_clk_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = osc_clk_pkg::ST_IDLE;
      end
    endcase
  end

  clk_ratio_decode u_ratio (
    .pre_code(pre_reg),
    .post_code(post_reg),
    .fbd_code(fbd_reg),
    .fast_rc_code(fast_rc_reg),
    .doze_code(doze_reg),
    .doze_enable(doze_enable_reg),
    .ratio(ratio)
  );

  // configuration is caught while power-on reset is held and kept afterwards
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= '{start_source_cfg, primary_submode_cfg, switch_monitor_cfg};
    end
  end

  // APB answer: zero wait states
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_hit;
      if (setup) begin
        prdata <= {16'h0000, rd_word};
      end
    end
  end

  // unlock sequencer; any other write consumes the unlock
  always_ff @(posedge clk_sys) begin
    if (rst | warm_rst) begin
      unlock_reg <= 2'h0;
    end else if (key_wr) begin
      if (wdata == `OSC_KEY_FIRST) begin
        unlock_reg <= 2'h1;
      end else if (wdata == `OSC_KEY_SECOND && unlock_reg == 2'h1) begin
        unlock_reg <= 2'h2;
      end else begin
        unlock_reg <= 2'h0;
      end
    end else if (wr_done) begin
      unlock_reg <= 2'h0;
    end
  end

  // oscillator control fields, cleared only by power-on reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      next_reg <= start_source_cfg;
      clock_lock_reg <= 1'b0;
      pin_lock_reg <= 1'b0;
      secondary_osc_enable <= 1'b0;
    end else if (ctrl_wr) begin
      if (sw_enabled) begin
        next_reg <= wdata[`CTRL_NEXT_LSB +: 3];
      end
      clock_lock_reg <= wdata[`CTRL_CLOCK_LOCK_BIT];
      pin_lock_reg <= wdata[`CTRL_PIN_LOCK_BIT];
      secondary_osc_enable <= wdata[`CTRL_SEC_EN_BIT];
    end
  end

  // status flags; a hardware set beats a software clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fail_reg <= 1'b0;
      pll_lock_reg <= 1'b0;
      fail_prev_reg <= 1'b0;
      new_clk_prev_reg <= 1'b0;
    end else begin
      fail_reg <= fail_set | (fail_reg & ~fail_clear);
      pll_lock_reg <= ~valid_start & pll_in_use & pll_lock_s;
      fail_prev_reg <= fail_s;
      new_clk_prev_reg <= new_clk_s;
    end
  end

  // switch request: held at zero while switching is disabled
  always_ff @(posedge clk_sys) begin
    if (rst || !sw_enabled) begin
      sw_req_reg <= 1'b0;
    end else if (req_set) begin
      sw_req_reg <= 1'b1;
    end else if (abort_req || settle_done) begin
      sw_req_reg <= 1'b0;
    end
  end

  // switch sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= osc_clk_pkg::ST_IDLE;
      current_source <= start_source_cfg;
      target_source <= start_source_cfg;
      settle_cnt_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (valid_start) begin
        target_source <= next_reg;
      end
      if (state_reg != osc_clk_pkg::ST_SETTLE) begin
        settle_cnt_reg <= 4'h0;
      end else if (new_clk_rise) begin
        settle_cnt_reg <= settle_cnt_reg + 4'h1;
      end
      if (settle_done) begin
        current_source <= target_source;
      end
    end
  end

  // clock divisor and feedback registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      recover_reg <= 1'b0;
      doze_reg <= `DIV_DOZE_RESET;
      fast_rc_reg <= `DIV_FAST_RC_RESET;
      post_reg <= `DIV_POST_RESET;
      pre_reg <= `DIV_PRE_RESET;
      fbd_reg <= `FBD_RESET;
    end else begin
      if (div_wr) begin
        recover_reg <= wdata[`DIV_RECOVER_BIT];
        doze_reg <= wdata[`DIV_DOZE_LSB +: 3];
        fast_rc_reg <= wdata[`DIV_FAST_RC_LSB +: 3];
        post_reg <= wdata[`DIV_POST_LSB +: 2];
        pre_reg <= wdata[`DIV_PRE_LSB +: 5];
      end
      if (fbd_wr) begin
        fbd_reg <= wdata[`FBD_LSB +: 9];
      end
    end
  end

  // an interrupt with the recover bit set clears doze ahead of a software write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      doze_enable_reg <= 1'b0;
    end else if (irq_event && recover_reg) begin
      doze_enable_reg <= 1'b0;
    end else if (div_wr) begin
      doze_enable_reg <= wdata[`DIV_DOZE_EN_BIT];
    end
  end

  // registered outputs toward the clock tree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      primary_submode <= `OSC_SUB_EXT_CLOCK;
      pll_enable <= 1'b0;
      pps_wr_grant <= 1'b0;
      switch_busy <= 1'b0;
      clk_div <= '0;
    end else begin
      primary_submode <= cfg_reg.primary_submode;
      pll_enable <= pll_in_use;
      pps_wr_grant <= pps_wr_req & ~pin_lock_reg;
      switch_busy <= state_next != osc_clk_pkg::ST_IDLE;
      clk_div <= ratio;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_RSVD_ZERO: assert property (setup && sel_ctrl |=> prdata[15] == 1'b0 && prdata[11] == 1'b0 &&
    prdata[4] == 1'b0 && prdata[2] == 1'b0) else $error("reserved control bit read nonzero");
  AST_ABORT: assert property (abort_req && !req_set |=> !sw_req_reg && state_reg == osc_clk_pkg::ST_IDLE)
    else $error("same-source request not aborted");
  AST_START_CLEARS: assert property (valid_start |=> !pll_lock_reg ##0 state_reg == osc_clk_pkg::ST_WAIT_READY)
    else $error("valid switch start did not clear lock");
  AST_SWITCH_DONE: assert property (settle_done && !req_set |=> current_source == $past(target_source) && !sw_req_reg)
    else $error("switch did not complete");
  AST_SETTLE_START: assert property ($rose(state_reg == osc_clk_pkg::ST_SETTLE) |-> settle_cnt_reg == 4'h0)
    else $error("settle count not cleared");
  AST_UNLOCK: assert property (wr_done && sel_ctrl && !unlocked |=> pin_lock_reg == $past(pin_lock_reg) &&
    clock_lock_reg == $past(clock_lock_reg)) else $error("locked control write took effect");
  AST_RECOVER: assert property (irq_event && recover_reg |=> !doze_enable_reg ##1 clk_div.doze_div == 8'h01)
    else $error("interrupt did not restore one-to-one");
  AST_CLOCK_LOCK: assert property (lock_active && !sw_req_reg && state_reg == osc_clk_pkg::ST_IDLE |=> !sw_req_reg)
    else $error("switch requested while clock locked");
  AST_FAIL_SET: assert property (fail_set |=> fail_reg) else $error("clock failure not flagged");
  AST_PIN_GRANT: assert property (pps_wr_grant |-> $past(pps_wr_req) && !$past(pin_lock_reg))
    else $error("pin select write granted while locked");
  AST_SW_DISABLED: assert property (!sw_enabled |-> !sw_req_reg)
    else $error("switch request set with switching disabled");
endmodule
`default_nettype wire

// >>> osc_clk_params.svh
// offsets, field positions, reset values and counts of the oscillator control block
`ifndef OSC_CLK_PARAMS_SVH
`define OSC_CLK_PARAMS_SVH
`define OSC_ADDR_CTRL 8'h00
`define OSC_ADDR_DIV 8'h04
`define OSC_ADDR_FBD 8'h08
`define OSC_ADDR_KEY 8'h0C
`define OSC_KEY_FIRST 16'h00A5
`define OSC_KEY_SECOND 16'h005A
`define OSC_SRC_FAST_RC 3'h0
`define OSC_SRC_FAST_RC_PLL 3'h1
`define OSC_SRC_PRIMARY 3'h2
`define OSC_SRC_PRIMARY_PLL 3'h3
`define OSC_SRC_SECONDARY 3'h4
`define OSC_SRC_LOW_POWER_RC 3'h5
`define OSC_SRC_FAST_RC_DIV16 3'h6
`define OSC_SRC_FAST_RC_DIV_N 3'h7
`define OSC_SUB_HIGH_SPEED_XTAL 2'h2
`define OSC_SUB_STD_XTAL 2'h1
`define OSC_SUB_EXT_CLOCK 2'h0
`define OSC_SWMON_SWITCH_ONLY 2'h1
`define OSC_SWMON_BOTH 2'h0
`define OSC_SWMON_DISABLE_BIT 1
`define CTRL_CLOCK_LOCK_BIT 7
`define CTRL_PIN_LOCK_BIT 6
`define CTRL_FAIL_BIT 3
`define CTRL_SEC_EN_BIT 1
`define CTRL_SWITCH_REQ_BIT 0
`define CTRL_NEXT_LSB 8
`define DIV_RECOVER_BIT 15
`define DIV_DOZE_LSB 12
`define DIV_DOZE_EN_BIT 11
`define DIV_FAST_RC_LSB 8
`define DIV_POST_LSB 6
`define DIV_PRE_LSB 0
`define FBD_LSB 0
`define DIV_DOZE_RESET 3'h3
`define DIV_FAST_RC_RESET 3'h0
`define DIV_POST_RESET 2'h1
`define DIV_PRE_RESET 5'h00
`define FBD_RESET 9'h030
`define PRE_DIV_OFFSET 6'h02
`define FBD_MULT_OFFSET 10'h002
`define POST_CODE_DIV2 2'h0
`define POST_CODE_DIV4 2'h1
`define POST_CODE_DIV8 2'h3
`define POST_DIV2 4'h2
`define POST_DIV4 4'h4
`define POST_DIV8 4'h8
`define POST_DIV_RESERVED 4'h0
`define FAST_RC_TOP_CODE 3'h7
`define FAST_RC_TOP_DIV 9'h100
`define FAST_RC_UNIT_DIV 9'h001
`define DOZE_UNIT_DIV 8'h01
`define FCY_DIV 2'h2
`define SETTLE_EDGES 4'hA
`endif

// >>> osc_clk_pkg.sv
// types shared by the oscillator control block
`default_nettype none
package osc_clk_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_READY, ST_SETTLE} sw_state_t;
  typedef struct packed {
    logic [2:0] start_source;
    logic [1:0] primary_submode;
    logic [1:0] switch_monitor;
  } osc_cfg_t;
  typedef struct packed {
    logic [5:0] pre_div;
    logic [3:0] post_div;
    logic [9:0] fb_mult;
    logic [8:0] fast_rc_div;
    logic [7:0] doze_div;
    logic [1:0] fcy_div;
  } clk_div_t;
endpackage
`default_nettype wire

// >>> osc_sync3.sv
// three-stage synchroniser that passes a bit once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module osc_sync3 #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);
  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] stable_next;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign stable_next[i] = (ff2_reg[i] == ff3_reg[i]) ? ff3_reg[i] : stable_out[i];
    end
  endgenerate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      stable_out <= '0;
    end else begin
      ff1_reg <= async_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      stable_out <= stable_next;
    end
  end
endmodule
`default_nettype wire

// >>> oscillator_select_and_clock_divider_bench.sv
// self-checking bench for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
`include "osc_clk_params.svh"
module oscillator_select_and_clock_divider_bench;
  localparam logic [7:0] CTL = `OSC_ADDR_CTRL;
  localparam logic [7:0] DIV = `OSC_ADDR_DIV;
  localparam logic [7:0] FBD = `OSC_ADDR_FBD;
  localparam logic [7:0] KEY = `OSC_ADDR_KEY;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic warm_rst = 1'b0;
  logic [2:0] src_cfg = 3'h7;
  logic [1:0] sub_cfg = 2'h2;
  logic [1:0] swm_cfg = 2'h1;
  logic pll_lock_raw = 1'b0;
  logic osc_ready_raw = 1'b0;
  logic new_clk_raw = 1'b0;
  logic clk_fail_raw = 1'b0;
  logic irq_event = 1'b0;
  logic pps_wr_req = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] current_source;
  logic [2:0] target_source;
  logic [1:0] primary_submode;
  logic pll_enable;
  logic secondary_osc_enable;
  logic pps_wr_grant;
  logic switch_busy;
  osc_clk_pkg::clk_div_t clk_div;
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] q;
  logic e;
  logic [15:0] d;
  logic [9:0] fb = 10'h032;
  logic [3:0] post_tbl [4] = '{4'h2, 4'h4, 4'h0, 4'h8};

  osc_clk_ctrl dut (.clk_sys(clk_sys), .rst(rst), .warm_rst(warm_rst), .start_source_cfg(src_cfg),
    .primary_submode_cfg(sub_cfg), .switch_monitor_cfg(swm_cfg), .pll_lock_raw(pll_lock_raw),
    .osc_ready_raw(osc_ready_raw), .new_clk_raw(new_clk_raw), .clk_fail_raw(clk_fail_raw),
    .irq_event(irq_event), .pps_wr_req(pps_wr_req), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_source(current_source), .target_source(target_source), .primary_submode(primary_submode),
    .pll_enable(pll_enable), .secondary_osc_enable(secondary_osc_enable), .pps_wr_grant(pps_wr_grant),
    .switch_busy(switch_busy), .clk_div(clk_div));

  always #2.5 clk_sys = ~clk_sys;

  task final_report;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one apb transfer; request held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      final_report;
    end
  endtask

  task wr(input logic [7:0] a, input logic [15:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task rd(input logic [7:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0);
    chk(q, {16'h0, exp});
  endtask

  task uwr(input logic [7:0] a, input logic [15:0] wd);
    wr(KEY, `OSC_KEY_FIRST);
    wr(KEY, `OSC_KEY_SECOND);
    wr(a, wd);
  endtask

  task por(input logic [2:0] s, input logic [1:0] m, input logic [1:0] w);
    @(posedge clk_sys);
    rst <= 1'b1;
    src_cfg <= s;
    sub_cfg <= m;
    swm_cfg <= w;
    cyc(16);
    rst <= 1'b0;
  endtask

  // slow new-source clock, well under an eighth of the system rate
  task clk_edges(input int n);
    repeat (n) begin
      cyc(6);
      new_clk_raw <= 1'b1;
      cyc(6);
      new_clk_raw <= 1'b0;
    end
  endtask

  task wait_idle;
    int n;
    n = 0;
    while (switch_busy !== 1'b0 && n < 500) begin
      cyc(1);
      n++;
    end
    if (n >= 500) begin
      error_cnt++;
      final_report;
    end
  endtask

  task chkdiv(input logic [5:0] pre, input logic [3:0] post, input logic [8:0] fast_rc_osc, input logic [7:0] dz);
    cyc(2);
    chk(clk_div, {pre, post, fb, fast_rc_osc, dz, `FCY_DIV});
  endtask

  initial begin
    por(3'h7, 2'h2, 2'h1);
    rd(CTL, 16'h7700);
    chk(current_source, 3'h7);
    chk(primary_submode, 2'h2);
    rd(DIV, 16'h3040);
    rd(FBD, 16'h0030);
    chkdiv(6'h02, 4'h4, 9'h001, 8'h01);
    chk(pps_wr_grant, 1'b1);
    xfer(1'b1, 8'h10, 16'hFFFF);
    chk(e, 1'b1);
    rd(8'h10, 16'h0000);
    chk(e, 1'b1);
    wr(CTL, 16'h00C2);
    rd(CTL, 16'h7700);
    wr(FBD, 16'hFFFF);
    rd(FBD, 16'h01FF);
    fb = 10'h201;
    for (int i = 0; i < 8; i++) begin
      d = {1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 3'h0, i[2:0]};
      wr(DIV, d | 16'h0020);
      rd(DIV, d);
      chkdiv({3'h0, i[2:0]} + 6'h02, post_tbl[i[1:0]], (i == 7) ? 9'h100 : (9'h001 << i), 8'h01 << i);
    end
    irq_event <= 1'b1;
    cyc(1);
    irq_event <= 1'b0;
    rd(DIV, 16'h7FC7);
    wr(DIV, 16'hFFFF);
    irq_event <= 1'b1;
    cyc(1);
    irq_event <= 1'b0;
    rd(DIV, 16'hF7DF);
    chkdiv(6'h21, 4'h8, 9'h100, 8'h01);
    wr(KEY, `OSC_KEY_FIRST);
    wr(KEY, `OSC_KEY_SECOND);
    wr(DIV, 16'h3040);
    wr(CTL, 16'h0002);
    rd(CTL, 16'h7700);
    uwr(CTL, 16'hFA56);
    rd(CTL, 16'h7242);
    chk(secondary_osc_enable, 1'b1);
    chk(pps_wr_grant, 1'b0);
    uwr(CTL, 16'h0243);
    rd(CTL, 16'h7243);
    chk(switch_busy, 1'b1);
    clk_edges(8);
    chk(current_source, 3'h7);
    osc_ready_raw <= 1'b1;
    cyc(8);
    clk_edges(8);
    chk(switch_busy, 1'b1);
    clk_edges(4);
    wait_idle;
    chk(current_source, 3'h2);
    chk(target_source, 3'h2);
    rd(CTL, 16'h2242);
    uwr(CTL, 16'h0243);
    cyc(3);
    rd(CTL, 16'h2242);
    chk(switch_busy, 1'b0);
    uwr(CTL, 16'h00C2);
    rd(CTL, 16'h20C2);
    uwr(CTL, 16'h00C3);
    cyc(3);
    rd(CTL, 16'h20C2);
    chk(switch_busy, 1'b0);
    uwr(CTL, 16'h0100);
    rd(CTL, 16'h2100);
    chk(secondary_osc_enable, 1'b0);
    chk(pps_wr_grant, 1'b1);
    // primary to fast RC with PLL is a permitted direct switch
    uwr(CTL, 16'h0101);
    cyc(3);
    chk(pll_enable, 1'b1);
    clk_edges(12);
    chk(switch_busy, 1'b1);
    pll_lock_raw <= 1'b1;
    cyc(8);
    clk_edges(12);
    wait_idle;
    chk(current_source, 3'h1);
    cyc(6);
    rd(CTL, 16'h1120);
    wr(KEY, `OSC_KEY_FIRST);
    wr(KEY, `OSC_KEY_SECOND);
    @(posedge clk_sys);
    warm_rst <= 1'b1;
    cyc(1);
    warm_rst <= 1'b0;
    wr(CTL, 16'h0000);
    rd(CTL, 16'h1120);
    rd(DIV, 16'h3040);
    por(3'h2, 2'h1, 2'h0);
    rd(CTL, 16'h2200);
    chk(primary_submode, 2'h1);
    rd(DIV, 16'h3040);
    clk_fail_raw <= 1'b1;
    cyc(10);
    rd(CTL, 16'h2208);
    uwr(CTL, 16'h0200);
    rd(CTL, 16'h2200);
    // failure input stays high across reset: its edge must be ignored with the monitor off
    por(3'h4, 2'h0, 2'h2);
    cyc(8);
    rd(CTL, 16'h4400);
    uwr(CTL, 16'h0001);
    cyc(3);
    rd(CTL, 16'h4400);
    chk(switch_busy, 1'b0);
    final_report;
  end
endmodule
`default_nettype wire
